// file: hdl/ctm_pkg.sv
// Constants, types and the counting step shared by the timer block.
// Assumes an 8-bit register port at the printed special-register addresses.
package ctm_pkg;

    localparam int CTM_ADDR_W = 8;
    localparam int CTM_DATA_W = 8;

    // Register addresses
    localparam logic [7:0] CTM_ADDR_T01_CTRL = 8'h88;
    localparam logic [7:0] CTM_ADDR_T01_MODE = 8'h89;
    localparam logic [7:0] CTM_ADDR_T0_LOW = 8'h8A;
    localparam logic [7:0] CTM_ADDR_T1_LOW = 8'h8B;
    localparam logic [7:0] CTM_ADDR_T0_HIGH = 8'h8C;
    localparam logic [7:0] CTM_ADDR_T1_HIGH = 8'h8D;
    localparam logic [7:0] CTM_ADDR_T2_CTRL = 8'hC8;
    localparam logic [7:0] CTM_ADDR_T2_MODE = 8'hC9;
    localparam logic [7:0] CTM_ADDR_RCAP_LOW = 8'hCA;
    localparam logic [7:0] CTM_ADDR_RCAP_HIGH = 8'hCB;
    localparam logic [7:0] CTM_ADDR_T2_LOW = 8'hCC;
    localparam logic [7:0] CTM_ADDR_T2_HIGH = 8'hCD;

    // Reset values
    localparam logic [7:0] CTM_RST_REG = 8'h00;
    localparam logic [15:0] CTM_RST_WORD = 16'h0000;
    localparam logic [7:0] CTM_UNMAPPED_READ = 8'h00;

    // Timer0/1 control field positions
    localparam int CTM_T01C_TIMER1_OVERFLOW = 7;
    localparam int CTM_T01C_TIMER1_RUN = 6;
    localparam int CTM_T01C_TIMER0_OVERFLOW = 5;
    localparam int CTM_T01C_TIMER0_RUN = 4;

    // Timer0/1 mode field positions
    localparam int CTM_T01M_TIMER1_GATE = 7;
    localparam int CTM_T01M_TIMER1_COUNTER_SELECT = 6;
    localparam int CTM_T01M_TIMER1_MODE_LOW = 4;
    localparam int CTM_T01M_TIMER0_GATE = 3;
    localparam int CTM_T01M_TIMER0_COUNTER_SELECT = 2;
    localparam int CTM_T01M_TIMER0_MODE_LOW = 0;

    // Timer2 control field positions
    localparam int CTM_T2C_OVERFLOW = 7;
    localparam int CTM_T2C_EXTERNAL_TRIGGER_FLAG = 6;
    localparam int CTM_T2C_UART_RECEIVE_CLOCK_SELECT = 5;
    localparam int CTM_T2C_UART_TRANSMIT_CLOCK_SELECT = 4;
    localparam int CTM_T2C_TRIGGER_ENABLE = 3;
    localparam int CTM_T2C_RUN = 2;
    localparam int CTM_T2C_SOURCE_SELECT = 1;
    localparam int CTM_T2C_CAPTURE_OR_RELOAD_SELECT = 0;

    // Timer2 mode field positions
    localparam int CTM_T2M_FIRST_CAPTURE_ENABLE = 0;

    // Standard timer tick: system clock divided by twelve
    localparam int CTM_PRESCALE_DEF = 12;

    typedef enum logic [1:0] {
        CTM_MODE_13BIT,
        CTM_MODE_16BIT,
        CTM_MODE_8BIT_RELOAD,
        CTM_MODE_SPLIT
    } ctm_mode_e;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic wrap;
    } ctm_step_s;

    typedef struct packed {
        logic t0;
        logic t1;
        logic t2;
        logic trig;
    } ctm_pins_s;

    // One count step of a Timer0/1 style counter pair
    function automatic ctm_step_s ctm_step(input ctm_mode_e mode, input logic [7:0] low, input logic [7:0] high);
        ctm_step_s r;
        logic [12:0] c13;
        logic [15:0] c16;
        r.low = low;
        r.high = high;
        r.wrap = 1'b0;
        c13 = {high, low[4:0]} + 13'h0001;
        c16 = {high, low} + 16'h0001;
        unique case (mode)
            CTM_MODE_13BIT: begin
                r.high = c13[12:5];
                r.low = {low[7:5], c13[4:0]};
                r.wrap = (c13 == 13'h0000);
            end
            CTM_MODE_16BIT: begin
                r.high = c16[15:8];
                r.low = c16[7:0];
                r.wrap = (c16 == 16'h0000);
            end
            CTM_MODE_8BIT_RELOAD: begin
                r.wrap = (low == 8'hFF);
                r.low = r.wrap ? high : low + 8'h01;
            end
            CTM_MODE_SPLIT: begin
                r.wrap = (low == 8'hFF);
                r.low = low + 8'h01;
            end
        endcase
        return r;
    endfunction

endpackage

// file: hdl/ctm_timers.sv
// Timer0, Timer1 and Timer2 with their registers on a plain register port.
// Assumes pins synchronous to I_MCLK and a master that never overlaps strobes.
//
// Contract
// [R1] Mode 0: 13-bit count from high byte and low five bits, flag on wrap.
// [R2] Mode 1: Timer0/1 count 16 bits, flag on rollover to zero.
// [R3] Mode 2: low byte counts, on overflow flag set and reload from high byte.
// [R4] Mode 3: Timer0 low byte own controls; high byte uses Timer1 run and flag.
// [R5] Timer0 in mode 3: Timer1 still counts, but not its run bit or flag.
// [R6] Timer1 placed in mode 3 stops counting.
// [R7] Capture 1 off: Timer2 overflow sets bit 7 unless a UART select is set.
// [R8] Capture 1 on: bit 7 is capture 1 flag, set by Timer2 pin edge.
// [R9] Trigger pin edge with trigger enable sets bit 6; software clears.
// [R10] Bit 5 picks UART receive clock: Timer1 or Timer2 overflow pulses.
// [R11] Bit 4 picks UART transmit clock: Timer1 or Timer2 overflow pulses.
// [R12] Bit 3 gates trigger pin: edge reloads or captures per function select.
// [R13] Timer2 counts only while run bit 2 is set by software.
// [R14] Bit 1 picks Timer2 source: internal tick or falling Timer2 pin edges.
// [R15] Bit 0: reload or capture; forced to reload while a UART select is set.
// [R16] Reload/capture 2 pair holds reload and capture values; capture 1 separate.
// [R17] Capture 1 bytes read at CCh/CDh, chosen by capture 1 enable.
// [R18] Gate set: timer runs only while its gate pin is high and run set.
// [R19] Counter select: Timer0/1 counts falling edges of its count pin.
// [R20] Timer0/1 overflow flags clear on interrupt service entry.
// [R21] Timer2 count pair reachable only while capture 1 is disabled.
// [R22] Timer mode advances once per prescaled tick while running.
`timescale 1ns/1ps
module ctm_timers
    import ctm_pkg::*;
#(
    parameter int PRESCALE = CTM_PRESCALE_DEF
) (
    input logic I_MCLK,
    input logic I_NRST,
    input logic [CTM_ADDR_W-1:0] I_ADDR,
    input logic [CTM_DATA_W-1:0] I_WDATA,
    input logic I_WR,
    input logic I_RD,
    output logic [CTM_DATA_W-1:0] O_RDATA,
    input logic I_TIMER0_COUNT_PIN,
    input logic I_TIMER1_COUNT_PIN,
    input logic I_TIMER0_GATE_PIN,
    input logic I_TIMER1_GATE_PIN,
    input logic I_TIMER2_INPUT_PIN,
    input logic I_TRIGGER_INPUT_PIN,
    input logic I_TIMER0_ISR_ENTRY,
    input logic I_TIMER1_ISR_ENTRY,
    output logic O_TIMER0_OVERFLOW,
    output logic O_TIMER1_OVERFLOW,
    output logic O_TIMER2_INTERRUPT,
    output logic O_UART_RX_CLOCK,
    output logic O_UART_TX_CLOCK
);

    localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
    localparam logic [PW-1:0] PRESCALE_LAST = PW'(PRESCALE - 1);

    // Shared timing and pin history
    logic [PW-1:0] presc_ff, nxt_presc;
    ctm_pins_s pins_ff, nxt_pins, pins_now, fall;
    logic presc_tick;

    // Timer0/1 state
    logic [7:0] t01_ctrl_ff, nxt_t01_ctrl;
    logic [7:0] t01_mode_ff, nxt_t01_mode;
    logic [7:0] tl0_ff, nxt_tl0, th0_ff, nxt_th0;
    logic [7:0] tl1_ff, nxt_tl1, th1_ff, nxt_th1;
    ctm_mode_e mode0, mode1;
    ctm_step_s step0, step1;
    logic t0_split, t0_run, t0_tick, th0_tick, t1_run, t1_tick;
    logic tf0_set, tf1_set, t1_wrap;

    // Timer2 state
    logic [7:0] t2_ctrl_ff, nxt_t2_ctrl;
    logic [7:0] t2_mode_ff, nxt_t2_mode;
    logic [15:0] rcap_ff, nxt_rcap;
    logic [15:0] t2cnt_ff, nxt_t2cnt;
    logic [15:0] cap1_ff, nxt_cap1;
    logic baud, capmode, cap1en, t2_tick, t2_wrap, trig;

    // Bus side
    logic [7:0] rdata_ff, nxt_rdata;
    logic rx_clk_ff, nxt_rx_clk, tx_clk_ff, nxt_tx_clk;

    function automatic logic wr_at(input logic [7:0] addr);
        return I_WR && (I_ADDR == addr);
    endfunction

    // Prescaler and edge history
    always_comb begin
        pins_now = '{t0: I_TIMER0_COUNT_PIN, t1: I_TIMER1_COUNT_PIN,
                     t2: I_TIMER2_INPUT_PIN, trig: I_TRIGGER_INPUT_PIN};
        fall = pins_ff & ~pins_now;
        nxt_pins = pins_now;
        presc_tick = (presc_ff == PRESCALE_LAST);
        nxt_presc = presc_tick ? '0 : presc_ff + PW'(1); // [R22]
    end

    // Timer0 and Timer1
    always_comb begin
        mode0 = ctm_mode_e'(t01_mode_ff[CTM_T01M_TIMER0_MODE_LOW +: 2]);
        mode1 = ctm_mode_e'(t01_mode_ff[CTM_T01M_TIMER1_MODE_LOW +: 2]);
        t0_split = (mode0 == CTM_MODE_SPLIT);
        t0_run = t01_ctrl_ff[CTM_T01C_TIMER0_RUN]
                 && (!t01_mode_ff[CTM_T01M_TIMER0_GATE] || I_TIMER0_GATE_PIN); // [R18]
        t0_tick = t0_run && (t01_mode_ff[CTM_T01M_TIMER0_COUNTER_SELECT] ? fall.t0 : presc_tick); // [R19] [R22]
        // Split high byte is a plain timer borrowing Timer1's run bit
        th0_tick = t0_split && t01_ctrl_ff[CTM_T01C_TIMER1_RUN] && presc_tick; // [R4]
        // While Timer0 is split, Timer1 runs freely for baud use
        t1_run = t0_split ? 1'b1
                 : (t01_ctrl_ff[CTM_T01C_TIMER1_RUN]
                    && (!t01_mode_ff[CTM_T01M_TIMER1_GATE] || I_TIMER1_GATE_PIN)); // [R5] [R18]
        t1_tick = (mode1 != CTM_MODE_SPLIT) && t1_run
                  && (t01_mode_ff[CTM_T01M_TIMER1_COUNTER_SELECT] ? fall.t1 : presc_tick); // [R6] [R19]
        step0 = ctm_step(mode0, tl0_ff, th0_ff); // [R1] [R2] [R3]
        step1 = ctm_step(mode1, tl1_ff, th1_ff); // [R1] [R2] [R3]
        t1_wrap = t1_tick && step1.wrap;
        tf0_set = t0_tick && step0.wrap;
        tf1_set = t0_split ? (th0_tick && (th0_ff == 8'hFF)) : t1_wrap; // [R4] [R5]

        nxt_tl0 = t0_tick ? step0.low : tl0_ff;
        nxt_th0 = th0_ff;
        if (t0_split) begin
            if (th0_tick) begin
                nxt_th0 = th0_ff + 8'h01; // [R4]
            end
        end else if (t0_tick) begin
            nxt_th0 = step0.high;
        end
        nxt_tl1 = t1_tick ? step1.low : tl1_ff;
        nxt_th1 = t1_tick ? step1.high : th1_ff;
        // Software writes beat a same-cycle count
        if (wr_at(CTM_ADDR_T0_LOW)) begin
            nxt_tl0 = I_WDATA;
        end
        if (wr_at(CTM_ADDR_T0_HIGH)) begin
            nxt_th0 = I_WDATA;
        end
        if (wr_at(CTM_ADDR_T1_LOW)) begin
            nxt_tl1 = I_WDATA;
        end
        if (wr_at(CTM_ADDR_T1_HIGH)) begin
            nxt_th1 = I_WDATA;
        end

        nxt_t01_mode = wr_at(CTM_ADDR_T01_MODE) ? I_WDATA : t01_mode_ff;
        nxt_t01_ctrl = wr_at(CTM_ADDR_T01_CTRL) ? I_WDATA : t01_ctrl_ff;
        if (I_TIMER0_ISR_ENTRY) begin
            nxt_t01_ctrl[CTM_T01C_TIMER0_OVERFLOW] = 1'b0; // [R20]
        end
        if (I_TIMER1_ISR_ENTRY) begin
            nxt_t01_ctrl[CTM_T01C_TIMER1_OVERFLOW] = 1'b0; // [R20]
        end
        // Set wins over any clear in the same cycle
        if (tf0_set) begin
            nxt_t01_ctrl[CTM_T01C_TIMER0_OVERFLOW] = 1'b1; // [R1] [R2] [R3]
        end
        if (tf1_set) begin
            nxt_t01_ctrl[CTM_T01C_TIMER1_OVERFLOW] = 1'b1; // [R4]
        end
    end

    // Timer2
    always_comb begin
        baud = t2_ctrl_ff[CTM_T2C_UART_RECEIVE_CLOCK_SELECT] || t2_ctrl_ff[CTM_T2C_UART_TRANSMIT_CLOCK_SELECT];
        capmode = t2_ctrl_ff[CTM_T2C_CAPTURE_OR_RELOAD_SELECT] && !baud; // [R15]
        cap1en = t2_mode_ff[CTM_T2M_FIRST_CAPTURE_ENABLE];
        t2_tick = t2_ctrl_ff[CTM_T2C_RUN]
                  && (t2_ctrl_ff[CTM_T2C_SOURCE_SELECT] ? fall.t2 : presc_tick); // [R13] [R14] [R22]
        t2_wrap = t2_tick && (t2cnt_ff == 16'hFFFF);
        trig = t2_ctrl_ff[CTM_T2C_TRIGGER_ENABLE] && fall.trig; // [R12]

        nxt_t2cnt = t2cnt_ff;
        if (t2_tick) begin
            nxt_t2cnt = (t2_wrap && !capmode) ? rcap_ff : t2cnt_ff + 16'h0001; // [R15]
        end
        if (trig && !capmode) begin
            nxt_t2cnt = rcap_ff; // [R12] [R15]
        end
        nxt_rcap = rcap_ff;
        if (wr_at(CTM_ADDR_RCAP_LOW)) begin
            nxt_rcap[7:0] = I_WDATA;
        end
        if (wr_at(CTM_ADDR_RCAP_HIGH)) begin
            nxt_rcap[15:8] = I_WDATA;
        end
        // A capture is never lost to a same-cycle write
        if (trig && capmode) begin
            nxt_rcap = t2cnt_ff; // [R12] [R16]
        end
        nxt_cap1 = (cap1en && fall.t2) ? t2cnt_ff : cap1_ff; // [R8] [R16]
        // Count bytes are hidden behind capture 1 while it is enabled
        if (!cap1en) begin
            if (wr_at(CTM_ADDR_T2_LOW)) begin
                nxt_t2cnt[7:0] = I_WDATA; // [R21]
            end
            if (wr_at(CTM_ADDR_T2_HIGH)) begin
                nxt_t2cnt[15:8] = I_WDATA; // [R21]
            end
        end

        nxt_t2_mode = wr_at(CTM_ADDR_T2_MODE) ? I_WDATA : t2_mode_ff;
        nxt_t2_ctrl = wr_at(CTM_ADDR_T2_CTRL) ? I_WDATA : t2_ctrl_ff; // [R13]
        if (cap1en ? fall.t2 : (t2_wrap && !baud)) begin
            nxt_t2_ctrl[CTM_T2C_OVERFLOW] = 1'b1; // [R7] [R8]
        end
        if (trig) begin
            nxt_t2_ctrl[CTM_T2C_EXTERNAL_TRIGGER_FLAG] = 1'b1; // [R9]
        end

        nxt_rx_clk = t2_ctrl_ff[CTM_T2C_UART_RECEIVE_CLOCK_SELECT] ? t2_wrap : t1_wrap; // [R10]
        nxt_tx_clk = t2_ctrl_ff[CTM_T2C_UART_TRANSMIT_CLOCK_SELECT] ? t2_wrap : t1_wrap; // [R11]
    end

    // Read port: data only in the cycle after the strobe
    always_comb begin
        nxt_rdata = '0;
        if (I_RD) begin
            unique case (I_ADDR)
                CTM_ADDR_T01_CTRL: nxt_rdata = t01_ctrl_ff;
                CTM_ADDR_T01_MODE: nxt_rdata = t01_mode_ff;
                CTM_ADDR_T0_LOW: nxt_rdata = tl0_ff;
                CTM_ADDR_T1_LOW: nxt_rdata = tl1_ff;
                CTM_ADDR_T0_HIGH: nxt_rdata = th0_ff;
                CTM_ADDR_T1_HIGH: nxt_rdata = th1_ff;
                CTM_ADDR_T2_CTRL: nxt_rdata = t2_ctrl_ff;
                CTM_ADDR_T2_MODE: nxt_rdata = t2_mode_ff;
                CTM_ADDR_RCAP_LOW: nxt_rdata = rcap_ff[7:0];
                CTM_ADDR_RCAP_HIGH: nxt_rdata = rcap_ff[15:8];
                CTM_ADDR_T2_LOW: nxt_rdata = cap1en ? cap1_ff[7:0] : t2cnt_ff[7:0]; // [R17] [R21]
                CTM_ADDR_T2_HIGH: nxt_rdata = cap1en ? cap1_ff[15:8] : t2cnt_ff[15:8]; // [R17] [R21]
                default: nxt_rdata = CTM_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            presc_ff <= '0;
            pins_ff <= '0;
            t01_ctrl_ff <= CTM_RST_REG;
            t01_mode_ff <= CTM_RST_REG;
            tl0_ff <= CTM_RST_REG;
            th0_ff <= CTM_RST_REG;
            tl1_ff <= CTM_RST_REG;
            th1_ff <= CTM_RST_REG;
            t2_ctrl_ff <= CTM_RST_REG;
            t2_mode_ff <= CTM_RST_REG;
            rcap_ff <= CTM_RST_WORD;
            t2cnt_ff <= CTM_RST_WORD;
            cap1_ff <= CTM_RST_WORD;
            rdata_ff <= CTM_RST_REG;
            rx_clk_ff <= 1'b0;
            tx_clk_ff <= 1'b0;
        end else begin
            presc_ff <= nxt_presc;
            pins_ff <= nxt_pins;
            t01_ctrl_ff <= nxt_t01_ctrl;
            t01_mode_ff <= nxt_t01_mode;
            tl0_ff <= nxt_tl0;
            th0_ff <= nxt_th0;
            tl1_ff <= nxt_tl1;
            th1_ff <= nxt_th1;
            t2_ctrl_ff <= nxt_t2_ctrl;
            t2_mode_ff <= nxt_t2_mode;
            rcap_ff <= nxt_rcap;
            t2cnt_ff <= nxt_t2cnt;
            cap1_ff <= nxt_cap1;
            rdata_ff <= nxt_rdata;
            rx_clk_ff <= nxt_rx_clk;
            tx_clk_ff <= nxt_tx_clk;
        end
    end

    assign O_RDATA = rdata_ff;
    assign O_TIMER0_OVERFLOW = t01_ctrl_ff[CTM_T01C_TIMER0_OVERFLOW];
    assign O_TIMER1_OVERFLOW = t01_ctrl_ff[CTM_T01C_TIMER1_OVERFLOW];
    assign O_TIMER2_INTERRUPT = t2_ctrl_ff[CTM_T2C_OVERFLOW] || t2_ctrl_ff[CTM_T2C_EXTERNAL_TRIGGER_FLAG];
    assign O_UART_RX_CLOCK = rx_clk_ff;
    assign O_UART_TX_CLOCK = tx_clk_ff;

endmodule // ctm_timers

// file: tb/ctm_pins_model.sv
// Pin-side partner: count, gate, Timer2 and trigger pins.
// Assumes the bench calls its tasks in sequence.
`timescale 1ns/1ps
module ctm_pins_model (
    input wire logic i_clk,
    output logic [5:0] o_pins
);
    // Order: count0, count1, gate0, gate1, timer2, trigger
    initial o_pins = 6'h00;
    // Idle low, so each pulse gives one falling edge; two cycles per level
    task automatic fall(input int idx);
        @(posedge i_clk);
        o_pins[idx] <= !o_pins[idx];
        repeat (2) @(posedge i_clk);
        o_pins[idx] <= !o_pins[idx];
        repeat (2) @(posedge i_clk);
    endtask
    task automatic level(input int idx, input logic v);
        @(posedge i_clk);
        o_pins[idx] <= v;
    endtask
endmodule // ctm_pins_model

// file: tb/ctm_timers_properties.sv
// Port checker for the timer block.
// Assumes read and write strobes never overlap.
`timescale 1ns/1ps
module ctm_timers_properties
    import ctm_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_NRST,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic I_TIMER0_ISR_ENTRY,
    input wire logic I_TIMER1_ISR_ENTRY,
    input wire logic O_TIMER0_OVERFLOW,
    input wire logic O_TIMER1_OVERFLOW,
    input wire logic O_TIMER2_INTERRUPT,
    input wire logic O_UART_RX_CLOCK
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    property p_rdata_idle;
        !$past(I_RD) |-> O_RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_t2_flags;
        I_RD && I_ADDR == CTM_ADDR_T2_CTRL |=> (O_RDATA[7] | O_RDATA[6]) == $past(O_TIMER2_INTERRUPT);
    endproperty
    a_t2_flags: assert property (p_t2_flags) else $error("t2 flags differ");
    property p_t01_flags;
        I_RD && I_ADDR == CTM_ADDR_T01_CTRL |=> O_RDATA[7] == $past(O_TIMER1_OVERFLOW)
            && O_RDATA[5] == $past(O_TIMER0_OVERFLOW);
    endproperty
    a_t01_flags: assert property (p_t01_flags) else $error("t01 flags differ");
    property p_t1_stands;
        O_TIMER1_OVERFLOW && !I_TIMER1_ISR_ENTRY && !(I_WR && I_ADDR == CTM_ADDR_T01_CTRL) |=> O_TIMER1_OVERFLOW;
    endproperty
    a_t1_stands: assert property (p_t1_stands) else $error("t1 flag lost");
    property p_t0_stands;
        O_TIMER0_OVERFLOW && !I_TIMER0_ISR_ENTRY && !(I_WR && I_ADDR == CTM_ADDR_T01_CTRL) |=> O_TIMER0_OVERFLOW;
    endproperty
    a_t0_stands: assert property (p_t0_stands) else $error("t0 flag lost");
    property p_t2_stands;
        O_TIMER2_INTERRUPT && !(I_WR && I_ADDR == CTM_ADDR_T2_CTRL) |=> O_TIMER2_INTERRUPT;
    endproperty
    a_t2_stands: assert property (p_t2_stands) else $error("t2 flag lost");
    property p_rx_pulse;
        O_UART_RX_CLOCK |=> !O_UART_RX_CLOCK;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx clock too long");
    property p_mode_back;
        I_WR && I_ADDR == CTM_ADDR_T2_MODE ##2 I_RD && I_ADDR == CTM_ADDR_T2_MODE && !$past(I_WR)
            |=> O_RDATA == $past(I_WDATA, 3);
    endproperty
    a_mode_back: assert property (p_mode_back) else $error("mode readback");
endmodule // ctm_timers_properties

bind ctm_timers ctm_timers_properties u_props (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_TIMER0_ISR_ENTRY(I_TIMER0_ISR_ENTRY),
    .I_TIMER1_ISR_ENTRY(I_TIMER1_ISR_ENTRY), .O_TIMER0_OVERFLOW(O_TIMER0_OVERFLOW),
    .O_TIMER1_OVERFLOW(O_TIMER1_OVERFLOW), .O_TIMER2_INTERRUPT(O_TIMER2_INTERRUPT),
    .O_UART_RX_CLOCK(O_UART_RX_CLOCK));

// file: tb/ctm_timers_test.sv
// Self-checking bench for the timer block.
// Assumes PRESCALE=2; pins come from the partner model.
`timescale 1ns/1ps
module ctm_timers_test import ctm_pkg::*;;
    logic clk, nrst, wr_s, rd_s, isr0, isr1, ovf0, ovf1, t2int, rxc, txc;
    logic [7:0] addr, wdata, rdata, tl, th;
    logic [5:0] pins;
    logic [31:0] r;
    int err_count = 0, tests_run = 0, seed = 89154, rx_n = 0, tx_n = 0, f, n0, n1;
    logic [7:0] regs[13] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hC9, 8'hCA, 8'hCB,
        8'hCC, 8'hCD, 8'h00};
    ctm_timers #(.PRESCALE(2)) dut (.I_MCLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_TIMER0_COUNT_PIN(pins[0]),
        .I_TIMER1_COUNT_PIN(pins[1]), .I_TIMER0_GATE_PIN(pins[2]), .I_TIMER1_GATE_PIN(pins[3]),
        .I_TIMER2_INPUT_PIN(pins[4]), .I_TRIGGER_INPUT_PIN(pins[5]), .I_TIMER0_ISR_ENTRY(isr0),
        .I_TIMER1_ISR_ENTRY(isr1), .O_TIMER0_OVERFLOW(ovf0), .O_TIMER1_OVERFLOW(ovf1),
        .O_TIMER2_INTERRUPT(t2int), .O_UART_RX_CLOCK(rxc), .O_UART_TX_CLOCK(txc));
    ctm_pins_model pm (.i_clk(clk), .o_pins(pins));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        rx_n <= rx_n + rxc;
        tx_n <= tx_n + txc;
    end
    task automatic test_done;
        if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), rdata, exp);
    endtask
    // Reference count step, one falling edge per call
    function automatic void mstep(int m, inout logic [7:0] lo, inout logic [7:0] hi, inout int fl);
        int c;
        if (m == 0) begin
            c = {hi, lo[4:0]} + 1;
            fl |= c >> 13;
            lo[4:0] = c[4:0];
            hi = c[12:5];
        end else if (m == 1) begin
            c = {hi, lo} + 1;
            fl |= c >> 16;
            {hi, lo} = c[15:0];
        end else begin
            fl |= (lo == 8'hFF);
            lo = (lo == 8'hFF) ? hi : lo + 8'h01;
        end
    endfunction
    initial begin
        #200000;
        err_count++;
        test_done();
    end
    initial begin
        {nrst, wr_s, rd_s, isr0, isr1} = 5'h00;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 3; m++) begin
                r = $random(seed);
                tl = (m == 0) ? {r[7:5], 5'h1E} : 8'hFE;
                th = (m == 2) ? r[15:8] : 8'hFF;
                wr(8'h88, 8'h00);
                wr(8'h89, 8'((8'h04 + m) << (4 * t)));
                wr(8'(8'h8A + t), tl);
                wr(8'(8'h8C + t), th);
                wr(8'h88, 8'(8'h10 << (2 * t)));
                f = 0;
                n0 = rx_n;
                n1 = tx_n;
                repeat (3) begin
                    pm.fall(t);
                    mstep(m, tl, th, f);
                end
                rd(8'(8'h8A + t), tl);
                rd(8'(8'h8C + t), th);
                rd(8'h88, 8'((f ? 8'h30 : 8'h10) << (2 * t)));
                chk("ovf", {7'h00, t ? ovf1 : ovf0}, 8'(f));
                chk("rx", 8'(rx_n - n0), 8'(t ? f : 0));
                chk("tx", 8'(tx_n - n1), 8'(t ? f : 0));
                @(posedge clk);
                isr1 <= (t == 1);
                isr0 <= (t == 0);
                @(posedge clk);
                {isr1, isr0} <= 2'b00;
                rd(8'h88, 8'(8'h10 << (2 * t)));
            end
            wr(8'h89, 8'(8'h0D << (4 * t)));
            wr(8'(8'h8A + t), 8'h10);
            pm.fall(t);
            rd(8'(8'h8A + t), 8'h10);
            pm.level(2 + t, 1'b1);
            pm.fall(t);
            rd(8'(8'h8A + t), 8'h11);
        end
        // Timer0 split: Timer1 counts without its run bit, high byte of Timer0 owns its flag
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h43);
        wr(8'h8B, 8'h20);
        pm.fall(1);
        rd(8'h8B, 8'h21);
        wr(8'h8C, 8'hFF);
        wr(8'h88, 8'h40);
        repeat (4) @(posedge clk);
        rd(8'h88, 8'hC0);
        wr(8'h89, 8'h70);
        wr(8'h88, 8'h40);
        wr(8'h8B, 8'h10);
        pm.fall(1);
        rd(8'h8B, 8'h10);
        r = $random(seed);
        wr(8'hCA, r[7:0]);
        wr(8'hCB, r[15:8]);
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h06);
        repeat (2) pm.fall(4);
        rd(8'hCC, r[7:0]);
        rd(8'hCD, r[15:8]);
        rd(8'hC8, 8'h86);
        chk("t2int", {7'h00, t2int}, 8'h01);
        wr(8'hC8, 8'h07);
        wr(8'hCC, 8'h5A);
        wr(8'hCD, 8'hA5);
        pm.fall(5);
        rd(8'hC8, 8'h07);
        rd(8'hCA, r[7:0]);
        wr(8'hC8, 8'h0F);
        pm.fall(5);
        rd(8'hC8, 8'h4F);
        rd(8'hCA, 8'h5A);
        rd(8'hCB, 8'hA5);
        wr(8'hC8, 8'h0E);
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        pm.fall(5);
        rd(8'hCC, 8'h5A);
        rd(8'hC8, 8'h4E);
        wr(8'hC8, 8'h02);
        pm.fall(4);
        rd(8'hCC, 8'h5A);
        wr(8'hCC, 8'hFF);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h37);
        n0 = rx_n;
        n1 = tx_n;
        pm.fall(4);
        rd(8'hCD, 8'hA5);
        rd(8'hC8, 8'h37);
        chk("rx", 8'(rx_n - n0), 8'h01);
        chk("tx", 8'(tx_n - n1), 8'h01);
        wr(8'hC8, 8'h00);
        wr(8'hC9, 8'h01);
        wr(8'hCC, 8'h00);
        pm.fall(4);
        rd(8'hC8, 8'h80);
        rd(8'hCC, 8'h5A);
        rd(8'hCD, 8'hA5);
        wr(8'hC9, 8'h00);
        rd(8'hC9, 8'h00);
        rd(8'hCC, 8'h5A);
        wr(8'hCC, 8'h33);
        rd(8'hCC, 8'h33);
        wr(8'hC9, 8'h01);
        rd(8'hCC, 8'h5A);
        test_done();
    end
endmodule // ctm_timers_test
